// *** rlk_defines.svh ***
// register offsets, field positions, reset values and timing for the polled link scheduler
`ifndef RLK_DEFINES_SVH
`define RLK_DEFINES_SVH
`define RLK_OFF_OPT     8'h00
`define RLK_OFF_GRANT   8'h04
`define RLK_OFF_REPLY   8'h08
`define RLK_OFF_IVL     8'h0c
`define RLK_OFF_DROP    8'h10
`define RLK_OFF_STAT    8'h14
`define RLK_OPT_SLAVE   0
`define RLK_OPT_MDIS    9
`define RLK_BASE_DEC    10'h064
`define RLK_BASE_CONT   10'h0c8
`define RLK_BASE_CYC    10'h12c
`define RLK_BASE_END    10'h190
`define RLK_RELAY_OFS   8'h64
`define RLK_RST_REPLY   16'h00c8
`define RLK_RST_IVL     16'h000a
`define RLK_RST_DROP    7'h00
`define RLK_TICK_NS     10000000
`define RLK_CLK_NS      8
`endif

// *** rlk_pkg.sv ***
// types shared by the polled link scheduler
package rlk_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_KEY  = 5'h02,
      ST_SEND = 5'h04,
      ST_WAIT = 5'h08,
      ST_IVL  = 5'h10
   } rlk_state_t;
   typedef enum logic [1:0] {
      K_MSG   = 2'h0,
      K_GRANT = 2'h1,
      K_RELAY = 2'h2
   } rlk_kind_t;
   typedef enum logic [2:0] {
      G_OFF    = 3'h0,
      G_SINGLE = 3'h1,
      G_DEC    = 3'h2,
      G_CONT   = 3'h3,
      G_CYC    = 3'h4
   } rlk_gmode_t;
endpackage

// *** rlk_polled_link_bid_scheduler.sv ***
// polled remote link unit: grant scheduler (master) and queue/repeater (slave)
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rlk_defines.svh"
module rlk_polled_link_bid_scheduler #(
   parameter int unsigned DEPTH    = 4,
   parameter int unsigned TICK_CYC = `RLK_TICK_NS / `RLK_CLK_NS
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        loc_valid_i,
   input  wire logic [31:0] loc_data_i,
   output logic             loc_ready_o,
   output logic             dlv_valid_o,
   output logic [31:0]      dlv_data_o,
   input  wire logic        rx_valid_i,
   input  wire logic        rx_grant_i,
   input  wire logic [31:0] rx_data_i,
   input  wire logic        rx_done_i,
   input  wire logic        carrier_i,
   input  wire logic        cts_i,
   output logic             rts_o,
   output logic             tx_valid_o,
   output logic             tx_grant_o,
   output logic [31:0]      tx_data_o
);
   import rlk_pkg::*;
   localparam int QW = $clog2(DEPTH);

   rlk_state_t st, next_st;
   rlk_kind_t  cur_kind, sel_kind;
   rlk_gmode_t gmode;
   logic [31:0] cur_data, sel_data, relay_data;
   logic [31:0] opt;
   logic [15:0] reply_to, ivl, tmr;
   logic [6:0]  own, gaddr, gstart;
   logic [31:0] pcnt;
   logic [31:0] mem [DEPTH];
   logic [QW-1:0] wp, rp;
   logic [QW:0]   qcnt;
   logic cts_m, cts_s, car_m, car_s;
   logic gnt_pend, relay_pend, from_ivl;
   logic mst, slv, q_empty, push, pop, launch, sel_go;
   logic tick, to_hit, ivl_done, wait_end, ivl_end, grant_end;
   logic wr, rd_setup, gw;
   logic [9:0] gv;

   // two-stage synchronisers for the modem pins
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cts_m <= 1'b0;
         cts_s <= 1'b0;
         car_m <= 1'b0;
         car_s <= 1'b0;
      end else begin
         cts_m <= cts_i;
         cts_s <= cts_m;
         car_m <= carrier_i;
         car_s <= car_m;
      end
   end

   assign mst = !opt[`RLK_OPT_SLAVE] && !opt[`RLK_OPT_MDIS];
   assign slv = opt[`RLK_OPT_SLAVE];

   // apb decode; zero wait states, answer in the access cycle
   assign wr       = psel_i && penable_i && pwrite_i;
   assign rd_setup = psel_i && !penable_i && !pwrite_i;
   assign pready_o = 1'b1;
   assign gw = wr && paddr_i == `RLK_OFF_GRANT;
   assign gv = pwdata_i[9:0];

   always_comb begin
      pslverr_o = psel_i && penable_i;
      unique case (paddr_i)
         `RLK_OFF_OPT, `RLK_OFF_GRANT, `RLK_OFF_REPLY,
         `RLK_OFF_IVL, `RLK_OFF_DROP, `RLK_OFF_STAT: pslverr_o = 1'b0;
         default: ;
      endcase
   end

   // configuration registers
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         opt      <= 32'h0000_0000;
         reply_to <= `RLK_RST_REPLY;
         ivl      <= `RLK_RST_IVL;
         own      <= `RLK_RST_DROP;
      end else if (wr) begin
         if (paddr_i == `RLK_OFF_OPT)
            opt <= pwdata_i;
         if (paddr_i == `RLK_OFF_REPLY)
            reply_to <= pwdata_i[15:0];
         if (paddr_i == `RLK_OFF_IVL)
            ivl <= pwdata_i[15:0];
         // whole word compared so that high bits cannot alias a legal drop
         if (paddr_i == `RLK_OFF_DROP && pwdata_i <= 32'h0000_0063)
            own <= pwdata_i[6:0];
      end
   end

   // read data is captured in setup so the access phase answers from a flop
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (rd_setup) begin
         unique case (paddr_i)
            `RLK_OFF_OPT:   prdata_o <= opt;
            `RLK_OFF_REPLY: prdata_o <= {16'h0000, reply_to};
            `RLK_OFF_IVL:   prdata_o <= {16'h0000, ivl};
            `RLK_OFF_DROP:  prdata_o <= {25'h0, own};
            `RLK_OFF_GRANT: prdata_o <= {8'h00, gstart, 7'h00, gmode, gaddr};
            `RLK_OFF_STAT:  prdata_o <= {19'h0, gnt_pend, relay_pend, st,
                                         2'h0, 4'(qcnt)};
            default:        prdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // grant sequencer: values 0-99 single, +100 down, +200 repeat, +300 cycle
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         gmode  <= G_OFF;
         gaddr  <= 7'h00;
         gstart <= 7'h00;
      end else if (gw && pwdata_i[31:10] == 22'h0 && gv < `RLK_BASE_END) begin
         if (gv < `RLK_BASE_DEC) begin
            gmode <= G_SINGLE;
            gaddr <= gv[6:0];
         end else if (gv < `RLK_BASE_CONT) begin
            gmode <= G_DEC;
            gaddr <= 7'(gv - `RLK_BASE_DEC);
         end else if (gv < `RLK_BASE_CYC) begin
            gmode <= G_CONT;
            gaddr <= 7'(gv - `RLK_BASE_CONT);
         end else begin
            gmode <= G_CYC;
            gaddr <= 7'(gv - `RLK_BASE_CYC);
         end
         gstart <= 7'(gv % 10'd100);
      end else if (grant_end && gmode == G_SINGLE) begin
         gmode <= G_OFF;
      end else if (ivl_end) begin
         unique case (gmode)
            G_DEC: begin
               if (gaddr == 7'h00)
                  gmode <= G_OFF;
               else
                  gaddr <= gaddr - 7'h01;
            end
            G_CYC: gaddr <= (gaddr == 7'h00) ? gstart : gaddr - 7'h01;
            default: ;
         endcase
      end
   end

   // local message queue; oldest entry leaves first
   assign q_empty     = qcnt == '0;
   assign loc_ready_o = qcnt != (QW+1)'(DEPTH);
   assign push        = loc_valid_i && loc_ready_o;
   assign pop         = launch && sel_kind == K_MSG;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wp   <= '0;
         rp   <= '0;
         qcnt <= '0;
      end else begin
         if (push) begin
            mem[wp] <= loc_data_i;
            wp      <= QW'((wp + 1'b1) % DEPTH);
         end
         if (pop)
            rp <= QW'((rp + 1'b1) % DEPTH);
         qcnt <= qcnt + (QW+1)'(push) - (QW+1)'(pop);
      end
   end

   // receive side: grants for this drop, relays, local delivery
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         gnt_pend    <= 1'b0;
         relay_pend  <= 1'b0;
         relay_data  <= 32'h0000_0000;
         dlv_valid_o <= 1'b0;
         dlv_data_o  <= 32'h0000_0000;
      end else begin
         dlv_valid_o <= 1'b0;
         if (launch && sel_kind == K_MSG && slv)
            gnt_pend <= 1'b0;
         if (launch && sel_kind == K_RELAY)
            relay_pend <= 1'b0;
         if (rx_valid_i && rx_grant_i) begin
            // an empty queue simply lets the grant lapse; grants never relay
            if (slv && rx_data_i[6:0] == own && !q_empty)
               gnt_pend <= 1'b1;
         end else if (rx_valid_i) begin
            if (slv && rx_data_i[7:0] == {1'b0, own} + `RLK_RELAY_OFS) begin
               relay_pend <= 1'b1;
               relay_data <= {8'h00, rx_data_i[31:8]};
            end else if (!slv || rx_data_i[7:0] == {1'b0, own}) begin
               dlv_valid_o <= 1'b1;
               dlv_data_o  <= {8'h00, rx_data_i[31:8]};
            end
         end
      end
   end

   // choose what to put on the link next
   always_comb begin
      sel_go   = 1'b0;
      sel_kind = K_MSG;
      sel_data = mem[rp];
      if (st == ST_IVL) begin
         sel_go = mst && !q_empty;
      end else if (mst) begin
         if (gmode != G_OFF) begin
            sel_go   = 1'b1;
            sel_kind = K_GRANT;
            sel_data = {25'h0, gaddr};
         end else begin
            sel_go = !q_empty;
         end
      end else if (slv) begin
         if (relay_pend) begin
            sel_go   = 1'b1;
            sel_kind = K_RELAY;
            sel_data = relay_data;
         end else begin
            sel_go = gnt_pend && !q_empty;
         end
      end
   end

   // tick prescaler and tick counter, restarted on every state change
   assign tick     = pcnt == TICK_CYC - 1;
   assign to_hit   = tmr >= reply_to;
   assign ivl_done = tmr >= ivl;
   always_ff @(posedge clk_i) begin
      if (!rstn_i || st != next_st) begin
         pcnt <= 32'h0000_0000;
         tmr  <= 16'h0000;
      end else begin
         pcnt <= tick ? 32'h0000_0000 : pcnt + 32'h0000_0001;
         if (tick && tmr != 16'hffff)
            tmr <= tmr + 16'h0001;
      end
   end

   assign wait_end  = st == ST_WAIT && (rx_done_i || to_hit);
   assign grant_end = wait_end && cur_kind == K_GRANT;
   assign ivl_end   = st == ST_IVL && next_st == ST_IDLE;
   assign launch    = (st == ST_IDLE || st == ST_IVL) && next_st == ST_KEY;

   // link sequencer: one transaction at a time, half duplex
   always_comb begin
      next_st = st;
      unique case (st)
         ST_IDLE: if (sel_go) next_st = ST_KEY;
         ST_KEY:  if (cts_s && !car_s) next_st = ST_SEND;
         ST_SEND: next_st = ST_WAIT;
         ST_WAIT: begin
            if (wait_end) begin
               if (from_ivl || (grant_end && gmode != G_SINGLE && gmode != G_OFF))
                  next_st = ST_IVL;
               else
                  next_st = ST_IDLE;
            end
         end
         ST_IVL: begin
            if (!mst)
               next_st = ST_IDLE;
            else if (sel_go)
               next_st = ST_KEY;
            else if (ivl_done)
               next_st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i)
         st <= ST_IDLE;
      else
         st <= next_st;
   end

   // latch the chosen item; note whether it was sent inside an interval
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cur_kind <= K_MSG;
         cur_data <= 32'h0000_0000;
         from_ivl <= 1'b0;
      end else if (launch) begin
         cur_kind <= sel_kind;
         cur_data <= sel_data;
         from_ivl <= st == ST_IVL;
      end
   end

   // transmit: rts keys the modem for the whole send, pulse carries the item
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rts_o      <= 1'b0;
         tx_valid_o <= 1'b0;
         tx_grant_o <= 1'b0;
         tx_data_o  <= 32'h0000_0000;
      end else begin
         rts_o      <= next_st == ST_KEY || next_st == ST_SEND;
         tx_valid_o <= next_st == ST_SEND;
         if (next_st == ST_SEND) begin
            tx_grant_o <= cur_kind == K_GRANT;
            tx_data_o  <= cur_data;
         end
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_tx_keyed: assert property (tx_valid_o |-> rts_o && $past(cts_s) && !$past(car_s))
      else $error("transmit without keyed clear channel");
   a_tx_single: assert property (tx_valid_o |=> !tx_valid_o [*2])
      else $error("second transmit too soon");
   a_dec_load: assert property (gw && pwdata_i == 32'h0000_0066
                               |=> gmode == G_DEC && gaddr == 7'h02)
      else $error("decrementing grant load wrong");
   a_cont_load: assert property (gw && pwdata_i == 32'h0000_00cf
                                |=> gmode == G_CONT && gaddr == 7'h07)
      else $error("continuous grant load wrong");
   a_dec_step: assert property (ivl_end && gmode == G_DEC && gaddr != 7'h00 && !gw
                               |=> gaddr == $past(gaddr) - 7'h01)
      else $error("grant drop not decremented");
   a_cyc_reload: assert property (ivl_end && gmode == G_CYC && gaddr == 7'h00 && !gw
                                 |=> gaddr == $past(gstart))
      else $error("cycling grant not reloaded");
   a_mdis_quiet: assert property (opt[`RLK_OPT_MDIS] && !slv |-> !(launch && sel_kind == K_GRANT))
      else $error("disabled master issued grant");
   a_one_per_grant: assert property (launch && slv && sel_kind == K_MSG
                                    |=> !gnt_pend || $past(rx_valid_i))
      else $error("grant not consumed");
   a_relay_send: assert property (launch && sel_kind == K_RELAY |=> cur_data == $past(relay_data))
      else $error("relay data altered");
endmodule
`default_nettype wire

// *** rlk_link_peer.sv ***
// far-end link peer: keys clear-to-send and answers each transmission while answer_i is high
`timescale 1ns/100ps
`default_nettype none
module rlk_link_peer (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       rts_i,
   input  wire logic       tx_valid_i,
   input  wire logic       answer_i,
   input  wire logic [7:0] delay_i,
   output logic            cts_o,
   output logic            carrier_o,
   output logic            done_o
);
   logic [7:0] cnt;
   // modem grants clear-to-send one cycle after the request and drops it one cycle after the request falls
   always_ff @(posedge clk_i) begin
      cts_o <= rstn_i & rts_i;
   end
   // the reply holds carrier up so the unit must stay quiet, then ends the transaction
   always_ff @(posedge clk_i) begin
      done_o <= rstn_i && !(tx_valid_i && answer_i) && cnt == 8'h01;
      if (!rstn_i) begin
         cnt <= 8'h00;
         carrier_o <= 1'b0;
      end else if (tx_valid_i && answer_i) begin
         cnt <= delay_i;
         carrier_o <= 1'b1;
      end else if (cnt == 8'h01) begin
         cnt <= 8'h00;
         carrier_o <= 1'b0;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end
endmodule
`default_nettype wire

// *** rlk_polled_link_bid_scheduler_test.sv ***
// self-checking bench for the polled link scheduler
`timescale 1ns/100ps
`default_nettype none
module rlk_polled_link_bid_scheduler_test;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} rlk_row_t;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr, delay;
   logic [31:0] pwdata, prdata, loc_data, dlv_data, rx_data, tx_data, r;
   logic        loc_valid, loc_ready, dlv_valid, rx_valid, rx_grant, rx_done;
   logic        carrier, cts, rts, tx_valid, tx_grant, answer;
   logic [32:0] txq[$];
   logic [31:0] dq[$];
   int          err_total, checks_done;
   rlk_row_t    rows[10];
   logic [32:0] dexp[5] = '{{1'b1, 32'h2}, {1'b0, 32'ha1}, {1'b0, 32'ha2}, {1'b1, 32'h1},
                            {1'b1, 32'h0}};

   // short tick keeps reply and interval waits to a few cycles
   rlk_polled_link_bid_scheduler #(.DEPTH(4), .TICK_CYC(4)) DUT (.clk_i(clk), .rstn_i(rstn),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .loc_valid_i(loc_valid),
      .loc_data_i(loc_data), .loc_ready_o(loc_ready), .dlv_valid_o(dlv_valid),
      .dlv_data_o(dlv_data), .rx_valid_i(rx_valid), .rx_grant_i(rx_grant), .rx_data_i(rx_data),
      .rx_done_i(rx_done), .carrier_i(carrier), .cts_i(cts), .rts_o(rts),
      .tx_valid_o(tx_valid), .tx_grant_o(tx_grant), .tx_data_o(tx_data));
   rlk_link_peer peer (.clk_i(clk), .rstn_i(rstn), .rts_i(rts), .tx_valid_i(tx_valid),
      .answer_i(answer), .delay_i(delay), .cts_o(cts), .carrier_o(carrier), .done_o(rx_done));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // record every link item and every local delivery
   always @(posedge clk) begin
      if (tx_valid === 1'b1) txq.push_back({tx_grant, tx_data});
      if (dlv_valid === 1'b1) dq.push_back(dlv_data);
   end
   // watchdog: the whole run needs under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high; an idle cycle follows the release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic push(input logic [31:0] d);
      loc_valid <= 1'b1;
      loc_data <= d;
      do @(posedge clk); while (loc_ready !== 1'b1);
      loc_valid <= 1'b0;
      loc_data <= ~d;
      @(posedge clk);
   endtask
   task automatic rxp(input logic g, input logic [31:0] d);
      rx_valid <= 1'b1;
      rx_grant <= g;
      rx_data <= d;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~d;
      repeat (60) @(posedge clk);
   endtask
   task automatic waitq(input int n);
      int k;
      k = 0;
      while (txq.size() < n && k < 3000) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      {rstn, psel, penable, pwrite, loc_valid, rx_valid, rx_grant} = 7'h00;
      {paddr, pwdata, loc_data, rx_data} = 104'h0;
      answer = 1'b0;
      delay = 8'h02;
      err_total = 0;
      checks_done = 0;
      rows = '{'{1'b0, 8'h08, 32'h0, 32'hc8, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'ha, 1'b0},
               '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h08, 32'h2, 32'h2, 1'b0},
               '{1'b1, 8'h0c, 32'h1, 32'h1, 1'b0}, '{1'b1, 8'h10, 32'h64, 32'h0, 1'b0},
               '{1'b1, 8'h10, 32'h3, 32'h3, 1'b0}, '{1'b1, 8'h18, 32'h5, 32'h0, 1'b1},
               '{1'b1, 8'h04, 32'h190, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'h464, 32'h0, 1'b0}};
      repeat (8) @(posedge clk);
      chk({28'h0, rts, tx_valid, dlv_valid, loc_ready, pready}, 33'h3);
      rstn <= 1'b1;
      @(posedge clk);
      // register rows: reset values, read-back, refused writes, unmapped place
      foreach (rows[i]) begin
         if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d, r, e);
         apb(1'b0, rows[i].a, 32'h0, r, e);
         chk({1'b0, r}, {1'b0, rows[i].x});
         chk({32'h0, e}, {32'h0, rows[i].e});
      end
      // single grant to an absent drop ends by timeout
      apb(1'b1, 8'h04, 32'h5, r, e);
      repeat (120) @(posedge clk);
      chk(33'(txq.size()), 33'h1);
      chk(txq[0], {1'b1, 32'h5});
      // downward sequence with messages arriving mid-grant
      txq.delete();
      answer <= 1'b1;
      apb(1'b1, 8'h04, 32'h66, r, e);
      waitq(1);
      push(32'ha1);
      push(32'ha2);
      waitq(5);
      repeat (100) @(posedge clk);
      chk(33'(txq.size()), 33'h5);
      foreach (dexp[i]) chk(txq[i], dexp[i]);
      // cycling sequence, stopped by master disable
      txq.delete();
      apb(1'b1, 8'h04, 32'h12d, r, e);
      waitq(4);
      apb(1'b1, 8'h00, 32'h200, r, e);
      for (int i = 0; i < 4; i++) chk(txq[i], {1'b1, 31'h0, ~i[0]});
      repeat (100) @(posedge clk);
      txq.delete();
      repeat (100) @(posedge clk);
      chk(33'(txq.size()), 33'h0);
      apb(1'b1, 8'h04, 32'hcf, r, e);
      apb(1'b1, 8'h00, 32'h0, r, e);
      waitq(3);
      for (int i = 0; i < 3; i++) chk(txq[i], {1'b1, 32'h7});
      // slave mode with a slow far end
      apb(1'b1, 8'h00, 32'h1, r, e);
      repeat (100) @(posedge clk);
      txq.delete();
      delay <= 8'h06;
      push(32'h11b1);
      push(32'h22b2);
      rxp(1'b1, 32'h9);
      rxp(1'b1, 32'h67);
      chk(33'(txq.size()), 33'h0);
      rxp(1'b1, 32'h3);
      chk(33'(txq.size()), 33'h1);
      chk(txq[0], {1'b0, 32'h11b1});
      rxp(1'b1, 32'h3);
      chk(txq[1], {1'b0, 32'h22b2});
      rxp(1'b1, 32'h3);
      chk(33'(txq.size()), 33'h2);
      rxp(1'b0, 32'h11223367);
      chk(txq[2], {1'b0, 32'h00112233});
      rxp(1'b0, 32'h44556603);
      chk({1'b0, dq[0]}, {1'b0, 32'h00445566});
      // no grant arrives, so the queue fills and pushes back
      for (int i = 0; i < 4; i++) push(32'h5500 + i);
      chk({32'h0, loc_ready}, 33'h0);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk({1'b0, r}, 33'h44);
      // mid-run reset empties the queue and restores the defaults
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      chk({32'h0, loc_ready}, 33'h1);
      rstn <= 1'b1;
      @(posedge clk);
      apb(1'b0, 8'h00, 32'h0, r, e);
      chk({1'b0, r}, 33'h0);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk({1'b0, r}, 33'h40);
      tally_and_finish();
   end
endmodule
`default_nettype wire
